//--- ioc_pkg.sv
// Register map, widths and bus states of the I/O line controller.
// Notes on behaviour
// - Bit n of every register is line n.
// - Filter enable write one turns filter on.
// - Filter disable write one turns filter off.
// - Filter status reads one where filter on.
// - Set-output write one drives value high.
// - Clear-output write one drives value low.
// - Output value reads the scheduled drive level.
// - Output value always readable, sometimes writable.
// - Direct output write only touches enabled lines.
// - Pin level reads the sampled line level.
// - Interrupt enable write one unmasks line.
// - Interrupt disable write one masks line.
// - Interrupt mask reads one where enabled.
// - Level change sets the line's status bit.
// - Status clears on read and on reset.
// - Open-drain enable write one sets multi-drive.
// - Multi-drive drives low only; disable ends it.
package ioc_pkg;
    localparam int IOC_LINES = 32;
    localparam int IOC_AW = 8;
    localparam logic [IOC_AW-1:0] IOC_FILTER_ENABLE = 8'h20;
    localparam logic [IOC_AW-1:0] IOC_FILTER_DISABLE = 8'h24;
    localparam logic [IOC_AW-1:0] IOC_FILTER_STATUS = 8'h28;
    localparam logic [IOC_AW-1:0] IOC_OUTPUT_SET = 8'h30;
    localparam logic [IOC_AW-1:0] IOC_OUTPUT_CLEAR = 8'h34;
    localparam logic [IOC_AW-1:0] IOC_OUTPUT_VALUE = 8'h38;
    localparam logic [IOC_AW-1:0] IOC_PIN_LEVEL = 8'h3c;
    localparam logic [IOC_AW-1:0] IOC_IRQ_ENABLE = 8'h40;
    localparam logic [IOC_AW-1:0] IOC_IRQ_DISABLE = 8'h44;
    localparam logic [IOC_AW-1:0] IOC_IRQ_MASK = 8'h48;
    localparam logic [IOC_AW-1:0] IOC_IRQ_STATUS = 8'h4c;
    localparam logic [IOC_AW-1:0] IOC_OD_ENABLE = 8'h50;
    localparam logic [IOC_AW-1:0] IOC_OD_DISABLE = 8'h54;
    localparam logic [IOC_AW-1:0] IOC_OD_STATUS = 8'h58;
    localparam logic [IOC_AW-1:0] IOC_DW_ENABLE = 8'ha0;
    localparam logic [IOC_AW-1:0] IOC_DW_DISABLE = 8'ha4;
    localparam logic [IOC_AW-1:0] IOC_DW_STATUS = 8'ha8;
    localparam logic [IOC_AW-1:0] IOC_IRQ_CLEAR = 8'hb0;
    localparam logic [31:0] IOC_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {
        IOC_IDLE = 2'b00,
        IOC_WAIT = 2'b01,
        IOC_DONE = 2'b10
    } ioc_bus_e;
endpackage

//--- ioc_filt_if.sv
// Interface between the register block and the per-line glitch filter.
`timescale 1ns/1ps
interface ioc_filt_if;
    logic [31:0] raw;
    logic [31:0] enable;
    logic [31:0] level;
    modport ctrl (output raw, output enable, input level);
    modport filt (input raw, input enable, output level);
endinterface

//--- ioc_filter.sv
// Per-line input glitch filter.
`timescale 1ns/1ps
module ioc_filter
    import ioc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    ioc_filt_if.filt fi
);
    logic [IOC_LINES-1:0] prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= IOC_ZERO;
        end else begin
            prev <= fi.raw;
        end
    end

    // A filtered line only moves once the input held the same level on two samples in a row.
    for (genvar n = 0; n < IOC_LINES; n++) begin : g_line
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                fi.level[n] <= 1'b0;
            end else if (!fi.enable[n] || fi.raw[n] == prev[n]) begin
                fi.level[n] <= fi.raw[n];
            end
        end
    end
endmodule

//--- ioc_io_line.sv
// APB register block of the 32-line I/O controller with filter, drive and change interrupt.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module ioc_io_line
    import ioc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IOC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [IOC_LINES-1:0] pad_in,
    output logic [IOC_LINES-1:0] pad_out,
    output logic [IOC_LINES-1:0] pad_oe,
    output logic irq
);
    ioc_filt_if fif ();

    ioc_bus_e bus_state;
    logic [IOC_LINES-1:0] filter_on;
    logic [IOC_LINES-1:0] output_value;
    logic [IOC_LINES-1:0] pin_level;
    logic [IOC_LINES-1:0] irq_mask;
    logic [IOC_LINES-1:0] irq_status;
    logic [IOC_LINES-1:0] open_drain;
    logic [IOC_LINES-1:0] direct_write;
    logic [IOC_LINES-1:0] change;
    logic [IOC_LINES-1:0] next_irq_status;
    logic [31:0] next_prdata;
    logic mapped;
    logic wr_fire;
    logic rd_take;

    function automatic logic hit(input logic [IOC_AW-1:0] a, input logic [IOC_AW-1:0] reg_off);
        hit = (a == reg_off);
    endfunction

    function automatic logic is_mapped(input logic [IOC_AW-1:0] a);
        is_mapped = hit(a, IOC_FILTER_ENABLE) || hit(a, IOC_FILTER_DISABLE) || hit(a, IOC_FILTER_STATUS) ||
                    hit(a, IOC_OUTPUT_SET) || hit(a, IOC_OUTPUT_CLEAR) || hit(a, IOC_OUTPUT_VALUE) ||
                    hit(a, IOC_PIN_LEVEL) || hit(a, IOC_IRQ_ENABLE) || hit(a, IOC_IRQ_DISABLE) ||
                    hit(a, IOC_IRQ_MASK) || hit(a, IOC_IRQ_STATUS) || hit(a, IOC_OD_ENABLE) ||
                    hit(a, IOC_OD_DISABLE) || hit(a, IOC_OD_STATUS) || hit(a, IOC_DW_ENABLE) ||
                    hit(a, IOC_DW_DISABLE) || hit(a, IOC_DW_STATUS) || hit(a, IOC_IRQ_CLEAR);
    endfunction

    assign fif.raw = pad_in;
    assign fif.enable = filter_on;

    ioc_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .fi(fif.filt)
    );

    // The access phase takes two cycles: the first latches read data, the second answers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state <= IOC_IDLE;
        end else begin
            case (bus_state)
                IOC_IDLE: begin
                    if (psel && penable) begin
                        bus_state <= IOC_WAIT;
                    end
                end
                IOC_WAIT: begin
                    bus_state <= IOC_DONE;
                end
                IOC_DONE: begin
                    bus_state <= IOC_IDLE;
                end
                default: begin
                    bus_state <= IOC_IDLE;
                end
            endcase
        end
    end

    assign rd_take = psel && penable && !pwrite && bus_state == IOC_IDLE;
    assign wr_fire = psel && penable && pwrite && bus_state == IOC_WAIT;
    assign mapped = is_mapped(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= (bus_state == IOC_IDLE) && psel && penable;
            pslverr <= (bus_state == IOC_IDLE) && psel && penable && !mapped;
        end
    end

    always_comb begin
        next_prdata = IOC_ZERO;
        case (paddr)
            IOC_FILTER_STATUS: next_prdata = filter_on;
            IOC_OUTPUT_VALUE: next_prdata = output_value;
            IOC_PIN_LEVEL: next_prdata = pin_level;
            IOC_IRQ_MASK: next_prdata = irq_mask;
            IOC_IRQ_STATUS: next_prdata = irq_status;
            IOC_OD_STATUS: next_prdata = open_drain;
            IOC_DW_STATUS: next_prdata = direct_write;
            default: next_prdata = IOC_ZERO;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= IOC_ZERO;
        end else if (rd_take) begin
            prdata <= next_prdata;
        end
    end

    // Each bit of every control register acts on the line with the same index.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_on <= IOC_ZERO;
        end else if (wr_fire && hit(paddr, IOC_FILTER_ENABLE)) begin
            filter_on <= filter_on | pwdata;
        end else if (wr_fire && hit(paddr, IOC_FILTER_DISABLE)) begin
            filter_on <= filter_on & ~pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_value <= IOC_ZERO;
        end else if (wr_fire && hit(paddr, IOC_OUTPUT_SET)) begin
            output_value <= output_value | pwdata;
        end else if (wr_fire && hit(paddr, IOC_OUTPUT_CLEAR)) begin
            output_value <= output_value & ~pwdata;
        end else if (wr_fire && hit(paddr, IOC_OUTPUT_VALUE)) begin
            output_value <= (output_value & ~direct_write) | (pwdata & direct_write);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direct_write <= IOC_ZERO;
        end else if (wr_fire && hit(paddr, IOC_DW_ENABLE)) begin
            direct_write <= direct_write | pwdata;
        end else if (wr_fire && hit(paddr, IOC_DW_DISABLE)) begin
            direct_write <= direct_write & ~pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= IOC_ZERO;
        end else if (wr_fire && hit(paddr, IOC_IRQ_ENABLE)) begin
            irq_mask <= irq_mask | pwdata;
        end else if (wr_fire && hit(paddr, IOC_IRQ_DISABLE)) begin
            irq_mask <= irq_mask & ~pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_drain <= IOC_ZERO;
        end else if (wr_fire && hit(paddr, IOC_OD_ENABLE)) begin
            open_drain <= open_drain | pwdata;
        end else if (wr_fire && hit(paddr, IOC_OD_DISABLE)) begin
            open_drain <= open_drain & ~pwdata;
        end
    end

    // Level seen after the filter; a difference from the last sample is a change.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level <= IOC_ZERO;
        end else begin
            pin_level <= fif.level;
        end
    end

    assign change = fif.level ^ pin_level;

    // A change arriving in the same cycle as a clear still sets its bit, so no event is lost.
    always_comb begin
        next_irq_status = irq_status;
        if (rd_take && hit(paddr, IOC_IRQ_STATUS)) begin
            next_irq_status = IOC_ZERO;
        end else if (wr_fire && hit(paddr, IOC_IRQ_CLEAR)) begin
            next_irq_status = irq_status & ~pwdata;
        end
        next_irq_status = next_irq_status | change;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= IOC_ZERO;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // With multi-drive on, a high value releases the pin instead of driving it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= IOC_ZERO;
            pad_oe <= IOC_ZERO;
        end else begin
            pad_out <= output_value;
            pad_oe <= ~open_drain | ~output_value;
        end
    end
endmodule

//--- ioc_pads.sv
// Board model around the I/O lines: pull-ups and external parts that pull lines low.
`timescale 1ns/1ps
module ioc_pads
    import ioc_pkg::*;
(
    input wire logic [IOC_LINES-1:0] pad_out,
    input wire logic [IOC_LINES-1:0] pad_oe,
    input wire logic [IOC_LINES-1:0] ext_low,
    output logic [IOC_LINES-1:0] pad_in
);
    // A released line rises on its pull-up; a low driver always wins, as on a wired-and net.
    assign pad_in = (~pad_oe | pad_out) & ~ext_low;
endmodule

//--- ioc_io_line_chk.sv
// Assertions at the ports of the I/O line controller.
`timescale 1ns/1ps
module ioc_io_line_chk
    import ioc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IOC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [IOC_LINES-1:0] pad_out,
    input wire logic [IOC_LINES-1:0] pad_oe,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wr = acc && pready && pwrite;
    wire hit = paddr inside {[8'h20:8'h28], [8'h30:8'h58], 8'ha0, 8'ha4, 8'ha8, 8'hb0};
    chk_ready_after: assert property (acc && !pready |=> pready)
        else $error("no answer one cycle into the access");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    chk_ready_access: assert property (pready |-> acc)
        else $error("ready outside an access");
    chk_err_decode: assert property (acc && pready && paddr[1:0] == 2'b00 |-> pslverr == !hit)
        else $error("error flag does not match the address decode");
    chk_od_high_only: assert property ($past(presetn) |-> (~pad_oe & ~pad_out) == 32'h0)
        else $error("line released while driving low");
    chk_set_to_pad: assert property (wr && paddr == IOC_OUTPUT_SET |-> ##2 (pad_out & $past(pwdata, 2)) == $past(pwdata, 2))
        else $error("set bits did not reach the pads");
    chk_clr_to_pad: assert property (wr && paddr == IOC_OUTPUT_CLEAR |-> ##2 (pad_out & $past(pwdata, 2)) == 32'h0)
        else $error("cleared bits did not reach the pads");
    chk_irq_masked: assert property (wr && paddr == IOC_IRQ_DISABLE && pwdata == 32'hffff_ffff |-> ##2 !irq)
        else $error("interrupt high with every line masked");
    cover property ($rose(irq));
    cover property (pslverr);
    cover property (pad_oe != 32'hffff_ffff);
endmodule
bind ioc_io_line ioc_io_line_chk i_ioc_io_line_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pad_out(pad_out),
    .pad_oe(pad_oe), .irq(irq));

//--- ioc_io_line_tb.sv
// Self-checking bench of the I/O line controller over APB with a pin model.
`timescale 1ns/1ps
module ioc_io_line_tb
    import ioc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] ext_low = 32'h0;
    logic [31:0] ov = 32'h0;
    logic [31:0] prdata, pad_in, pad_out, pad_oe, rd, v;
    logic pready, pslverr, irq, err;
    logic [31:0] st [4];
    logic [7:0] base [4] = '{IOC_FILTER_ENABLE, IOC_IRQ_ENABLE, IOC_OD_ENABLE, IOC_DW_ENABLE};
    integer seed = 56;
    integer miscompares = 0;
    integer checks = 0;
    integer i, k;
    always #10 pclk = ~pclk;
    ioc_io_line i_ioc_io_line (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq));
    ioc_pads i_ioc_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_low(ext_low), .pad_in(pad_in));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t %h %h", $time, s, e);
        end
    endtask
    // Expected output value after a direct write: only lines open to direct writes take the new data.
    function automatic logic [31:0] exp_direct(input logic [31:0] old, input logic [31:0] d, input logic [31:0] en);
        exp_direct = (old & ~en) | (d & en);
    endfunction
    task automatic apb(input logic wn, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wn;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic r(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task end_sim;
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge pclk);
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 4; k++) begin
            st[k] = 32'h0;
            r(base[k] + 8'h08);
            chk(rd, 32'h0);
        end
        r(8'h5c);
        chk({31'h0, err}, 32'h1);
        for (i = 0; i < 24; i++) begin
            k = i % 4;
            ext_low <= $random(seed);
            v = $random(seed);
            w(base[k], v);
            st[k] = st[k] | v;
            v = $random(seed);
            w(base[k] + 8'h04, v);
            st[k] = st[k] & ~v;
            r(base[k] + 8'h08);
            chk(rd, st[k]);
            v = $random(seed);
            w(IOC_OUTPUT_SET, v);
            ov = ov | v;
            v = $random(seed);
            w(IOC_OUTPUT_CLEAR, v);
            ov = ov & ~v;
            v = $random(seed);
            w(IOC_OUTPUT_VALUE, v);
            ov = exp_direct(ov, v, st[3]);
            r(IOC_OUTPUT_VALUE);
            chk(rd, ov);
            r(IOC_PIN_LEVEL);
            chk(rd, ov & ~ext_low);
        end
        ext_low <= 32'h0;
        w(IOC_OUTPUT_SET, 32'hffff_ffff);
        w(IOC_FILTER_DISABLE, 32'hffff_ffff);
        w(IOC_IRQ_ENABLE, 32'hffff_ffff);
        r(IOC_IRQ_STATUS);
        v = $random(seed);
        ext_low <= v;
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, |v});
        r(IOC_IRQ_STATUS);
        chk(rd, v);
        chk({31'h0, irq}, 32'h0);
        // A pulse of one clock must be seen with the filter off and dropped with it on.
        for (k = 0; k < 2; k++) begin
            w(k ? IOC_FILTER_ENABLE : IOC_FILTER_DISABLE, 32'hffff_ffff);
            r(IOC_IRQ_STATUS);
            ext_low <= v ^ 32'h1;
            @(posedge pclk);
            ext_low <= v;
            repeat (4) @(posedge pclk);
            r(IOC_IRQ_STATUS);
            chk(rd, k ? 32'h0 : 32'h1);
        end
        w(IOC_IRQ_DISABLE, 32'hffff_ffff);
        r(IOC_IRQ_MASK);
        chk(rd, 32'h0);
        ext_low <= ~v;
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        w(IOC_IRQ_CLEAR, 32'hffff_ffff);
        r(IOC_IRQ_STATUS);
        chk(rd, 32'h0);
        w(IOC_OD_ENABLE, 32'hffff_ffff);
        w(IOC_OUTPUT_CLEAR, v);
        repeat (2) @(posedge pclk);
        chk(pad_oe, v);
        w(IOC_OD_DISABLE, 32'hffff_ffff);
        repeat (2) @(posedge pclk);
        chk(pad_oe, 32'hffff_ffff);
        end_sim;
    end
endmodule
